/* File: src/scd_pkg.sv */
// shared constants and carrier types of the cache directory block
package scd_pkg;

    // ************************************************************
    // directory geometry
    // ************************************************************
    localparam int SETS = 64;
    localparam int WAYS = 2;
    localparam int TAG_W = 20;
    localparam int LINES = 8;
    localparam int WORDS = 4;
    localparam int LINE_BYTES = 16;
    localparam int SET_W = 6;
    localparam int LINE_W = 3;
    localparam int WORD_W = 2;
    localparam int CACHE_BYTES = SETS * WAYS * LINES * LINE_BYTES;

    // ************************************************************
    // address field positions
    // ************************************************************
    localparam int TAG_LSB = 12;
    localparam int SET_LSB = 7;
    localparam int LINE_LSB = 4;
    localparam int WORD_LSB = 2;
    localparam int UNIT_W = 2;

    // ************************************************************
    // reset values and sram timing counts
    // ************************************************************
    localparam logic REPL_RST = 1'b0;
    localparam logic TV_RST = 1'b0;
    localparam logic [1:0] FAST_FIRST_WAITS = 2'h1;
    localparam logic [1:0] FAST_NEXT_WAITS = 2'h0;
    localparam logic [1:0] SLOW_FIRST_WAITS = 2'h2;
    localparam logic [1:0] SLOW_NEXT_WAITS = 2'h1;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] byte_enables;
        logic write;
        logic cacheable;
        logic [1:0] nwords_m1;
    } scd_lreq_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] byte_enables;
    } scd_wt_t;

    // one bit per open-drain sram pin, pin low means asserted
    typedef struct packed {
        logic cache_read_strobe;
        logic cache_write_strobe;
        logic way_select_private;
        logic way_select_hit;
        logic [1:0] word_address_bits;
    } scd_od_t;

    typedef enum {SEQ_IDLE, SEQ_ADDR, SEQ_WAIT, SEQ_DATA, SEQ_RECOV} scd_seq_state_t;

endpackage

/* File: src/scd_way_match.sv */
// tag compare and line-valid check for one way of the selected set
`timescale 1ns/1ps
module scd_way_match (
    // stored entry
    input wire logic [scd_pkg::TAG_W-1:0] stored_tag,
    input wire logic tag_valid,
    input wire logic [scd_pkg::LINES-1:0] line_valid,
    // looked-up address
    input wire logic [scd_pkg::TAG_W-1:0] look_tag,
    input wire logic [scd_pkg::LINE_W-1:0] look_line,
    // configuration masks
    input wire logic [scd_pkg::TAG_W-1:0] tag_mask,
    input wire logic [scd_pkg::LINES-1:0] line_mask,
    // results
    output logic tag_hit,
    output logic line_hit
);

    // masked tag bits never take part in the compare
    // a cleared tag-valid bit hides tag and line bits alike
    assign tag_hit = tag_valid && (((stored_tag ^ look_tag) & tag_mask) == '0);
    // masked line bits read as invalid for smaller arrangements
    assign line_hit = tag_hit && line_valid[look_line] && line_mask[look_line];

endmodule

/* File: src/scd_sram_seq.sv */
// sram strobe, way, word-address and ready sequencer for one cache access
`timescale 1ns/1ps
module scd_sram_seq (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // access start
    input wire logic start,
    input wire logic is_write,
    input wire logic [1:0] nwords_m1,
    input wire logic [scd_pkg::WORD_W-1:0] first_word,
    input wire logic hit_way,
    input wire logic fast_timing,
    input wire logic private_hit_low,
    // status
    output logic busy,
    output logic done,
    output logic cache_ready,
    // pin enables
    output scd_pkg::scd_od_t pin_oe
);

    scd_pkg::scd_seq_state_t state_q, state_d;
    logic [1:0] cnt_q, cnt_d;
    logic [1:0] left_q, left_d;
    logic wr_q, fast_q, way_q, plow_q;
    logic [scd_pkg::WORD_W-1:0] wd_q;

    assign busy = (state_q != scd_pkg::SEQ_IDLE);
    assign done = (state_q == scd_pkg::SEQ_RECOV);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [1:0] nw;
        nw = fast_q ? scd_pkg::FAST_NEXT_WAITS : scd_pkg::SLOW_NEXT_WAITS;
        state_d = state_q;
        cnt_d = cnt_q;
        left_d = left_q;
        case (state_q)
            scd_pkg::SEQ_IDLE: begin
                if (start) begin
                    state_d = scd_pkg::SEQ_ADDR;
                    left_d = nwords_m1;
                    cnt_d = (fast_timing ? scd_pkg::FAST_FIRST_WAITS : scd_pkg::SLOW_FIRST_WAITS) - 2'h1;
                end
            end
            scd_pkg::SEQ_ADDR: state_d = scd_pkg::SEQ_WAIT;
            scd_pkg::SEQ_WAIT: begin
                if (cnt_q == 2'h0) begin
                    state_d = scd_pkg::SEQ_DATA;
                end else begin
                    cnt_d = cnt_q - 2'h1;
                end
            end
            scd_pkg::SEQ_DATA: begin
                // first word takes longer, later words only the next-word waits
                if (left_q == 2'h0) begin
                    state_d = scd_pkg::SEQ_RECOV;
                end else begin
                    left_d = left_q - 2'h1;
                    if (nw != 2'h0) begin
                        state_d = scd_pkg::SEQ_WAIT;
                        cnt_d = nw - 2'h1;
                    end
                end
            end
            scd_pkg::SEQ_RECOV: state_d = scd_pkg::SEQ_IDLE;
            default: state_d = scd_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= scd_pkg::SEQ_IDLE;
            cnt_q <= 2'h0;
            left_q <= 2'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            left_q <= left_d;
        end
    end

    // access attributes are frozen for the whole access
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wr_q <= 1'b0;
            fast_q <= 1'b0;
            way_q <= 1'b0;
            plow_q <= 1'b0;
        end else if (start && !busy) begin
            wr_q <= is_write;
            fast_q <= fast_timing;
            way_q <= hit_way;
            plow_q <= private_hit_low;
        end
    end

    // word address moves ahead on entry to each data cycle but the last, so it leads the data by one word
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wd_q <= '0;
        end else if (start && !busy) begin
            wd_q <= first_word;
        end else if (state_d == scd_pkg::SEQ_DATA && left_d != 2'h0) begin
            wd_q <= wd_q + 2'h1;
        end
    end

    // ************************************************************
    // registered pin enables and ready
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_oe <= '0;
            cache_ready <= 1'b0;
        end else begin
            // ready in address, data and recovery cycles only
            cache_ready <= (state_d == scd_pkg::SEQ_ADDR) || (state_d == scd_pkg::SEQ_DATA) ||
                           (state_d == scd_pkg::SEQ_RECOV);
            // read strobe spans address through last data cycle
            pin_oe.cache_read_strobe <= !wr_d_of() && (state_d != scd_pkg::SEQ_IDLE) &&
                                        (state_d != scd_pkg::SEQ_RECOV);
            // write strobe only while data is on the bus
            pin_oe.cache_write_strobe <= wr_d_of() && (state_d == scd_pkg::SEQ_DATA);
            // way bits pulled low while driven, held for the whole access
            pin_oe.way_select_hit <= (state_d != scd_pkg::SEQ_IDLE) && way_d_of();
            pin_oe.way_select_private <= (state_d != scd_pkg::SEQ_IDLE) && plow_d_of();
            pin_oe.word_address_bits <= (state_d != scd_pkg::SEQ_IDLE) ? wd_d_of() : 2'h0;
        end
    end

    // attributes as they will stand in the next cycle
    function automatic logic wr_d_of();
        return (start && !busy) ? is_write : wr_q;
    endfunction
    function automatic logic way_d_of();
        return (start && !busy) ? hit_way : way_q;
    endfunction
    function automatic logic plow_d_of();
        return (start && !busy) ? private_hit_low : plow_q;
    endfunction
    function automatic logic [1:0] wd_d_of();
        if (start && !busy) begin
            return first_word;
        end
        return (state_d == scd_pkg::SEQ_DATA && left_d != 2'h0) ? wd_q + 2'h1 : wd_q;
    endfunction

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_fast_single;
        cache_ready ##1 !cache_ready ##1 cache_ready ##1 done;
    endsequence

    a_fast_single_word: assert property (@(posedge core_clk) disable iff (!resetn)
        start && !busy && fast_timing && nwords_m1 == 2'h0 |=> s_fast_single)
        else $error("fast single-word access not three clocks");
    a_slow_four_words: assert property (@(posedge core_clk) disable iff (!resetn)
        start && !busy && !fast_timing && nwords_m1 == 2'h3 |-> ##11 done)
        else $error("slow four-word access not ten clocks");
    a_fast_four_words: assert property (@(posedge core_clk) disable iff (!resetn)
        start && !busy && fast_timing && nwords_m1 == 2'h3 |-> ##7 done)
        else $error("fast four-word access not six clocks");
    a_way_pins_stable: assert property (@(posedge core_clk) disable iff (!resetn)
        busy && $past(busy) && !done |-> $stable(pin_oe.way_select_hit) && $stable(pin_oe.way_select_private))
        else $error("way select moved during access");
    a_ready_addr_cycle: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == scd_pkg::SEQ_ADDR || state_q == scd_pkg::SEQ_DATA |-> cache_ready)
        else $error("ready missing in address or data cycle");

endmodule

/* File: src/scd_cache_dir.sv */
// two-way cache directory with snoop invalidation and external sram control
`timescale 1ns/1ps
module scd_cache_dir (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // configuration
    input wire logic cache_enable,
    input wire logic fast_timing,
    input wire logic private_hit_low,
    input wire logic [scd_pkg::TAG_W-1:0] tag_mask,
    input wire logic [scd_pkg::LINES-1:0] line_mask,
    input wire logic [1:0] interleave_log2,
    input wire logic [scd_pkg::UNIT_W-1:0] unit_id,
    // local bus request
    input wire logic lb_valid,
    input wire scd_pkg::scd_lreq_t lb_req,
    output logic lb_ready,
    output logic lb_hit,
    output logic lb_miss,
    output logic cache_ready,
    // write-through toward the system packet bus
    output logic wt_valid,
    output scd_pkg::scd_wt_t wt_req,
    input wire logic wt_ready,
    // system packet bus snoop
    input wire logic snoop_valid,
    input wire logic [31:0] snoop_addr,
    // line fill install
    input wire logic fill_valid,
    input wire logic [31:0] fill_addr,
    output logic repl_way,
    // open-drain sram pins
    output scd_pkg::scd_od_t sram_o,
    output scd_pkg::scd_od_t sram_oe,
    input wire scd_pkg::scd_od_t sram_i
);

    // ************************************************************
    // address decode helpers
    // ************************************************************
    // interleaved units take the low block-address bits as a unit number
    function automatic logic [scd_pkg::SET_W-1:0] set_of(input logic [31:0] a, input logic [1:0] il);
        logic [31:0] s;
        s = a >> (32'(scd_pkg::SET_LSB) + 32'(il));
        return s[scd_pkg::SET_W-1:0];
    endfunction

    function automatic logic unit_ok(input logic [31:0] a, input logic [1:0] il,
                                     input logic [scd_pkg::UNIT_W-1:0] id);
        logic [1:0] m;
        m = (il == 2'h0) ? 2'h0 : ((il == 2'h1) ? 2'h1 : 2'h3);
        return ((a[scd_pkg::SET_LSB +: scd_pkg::UNIT_W] ^ id) & m) == 2'h0;
    endfunction

    // ************************************************************
    // directory storage
    // ************************************************************
    // arrays never shrink; configuration only masks bits
    logic [scd_pkg::TAG_W-1:0] tag_q [scd_pkg::WAYS][scd_pkg::SETS];
    logic [scd_pkg::LINES-1:0] lv_q [scd_pkg::WAYS][scd_pkg::SETS];
    logic tv_q [scd_pkg::WAYS][scd_pkg::SETS];
    logic repl_q;

    // lookup port 0 local bus, 1 snoop, 2 fill
    logic [31:0] look_addr [3];
    logic [scd_pkg::SET_W-1:0] look_set [3];
    logic [scd_pkg::LINE_W-1:0] look_line [3];
    logic [scd_pkg::WAYS-1:0] way_line_hit [3];
    logic [scd_pkg::WAYS-1:0] way_tag_hit [3];

    assign look_addr[0] = lb_req.addr;
    assign look_addr[1] = snoop_addr;
    assign look_addr[2] = fill_addr;

    // all ways of the set are compared in the same cycle
    genvar p, w;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            assign look_set[p] = set_of(look_addr[p], interleave_log2);
            assign look_line[p] = look_addr[p][scd_pkg::LINE_LSB +: scd_pkg::LINE_W];
            for (w = 0; w < scd_pkg::WAYS; w++) begin : g_way
                scd_way_match u_match (
                    .stored_tag(tag_q[w][look_set[p]]),
                    .tag_valid(tv_q[w][look_set[p]]),
                    .line_valid(lv_q[w][look_set[p]]),
                    .look_tag(look_addr[p][scd_pkg::TAG_LSB +: scd_pkg::TAG_W]),
                    .look_line(look_line[p]),
                    .tag_mask(tag_mask),
                    .line_mask(line_mask),
                    .tag_hit(way_tag_hit[p][w]),
                    .line_hit(way_line_hit[p][w])
                );
            end
        end
    endgenerate

    // ************************************************************
    // request classification
    // ************************************************************
    logic seq_busy, seq_done;
    logic acc, mine, cacheable, l_hit, seq_start, nc_inv, snp_hit, fill_do, fill_way;

    assign lb_ready = !seq_busy && !wt_valid;
    assign acc = lb_valid && lb_ready;
    assign mine = unit_ok(lb_req.addr, interleave_log2, unit_id);
    assign cacheable = lb_req.cacheable && mine && cache_enable;
    assign l_hit = cacheable && (|way_line_hit[0]);
    // a write miss never starts an sram access, so nothing is allocated
    assign seq_start = acc && l_hit;
    assign nc_inv = acc && lb_req.write && !lb_req.cacheable && mine && (|way_line_hit[0]);
    assign snp_hit = snoop_valid && unit_ok(snoop_addr, interleave_log2, unit_id) && (|way_line_hit[1]);
    assign fill_do = fill_valid && cache_enable && unit_ok(fill_addr, interleave_log2, unit_id);
    // a block already resident keeps its way; otherwise the replacement way is taken
    assign fill_way = (|way_tag_hit[2]) ? way_tag_hit[2][1] : repl_q;
    assign repl_way = repl_q;

    // ************************************************************
    // directory update
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int s = 0; s < scd_pkg::SETS; s++) begin
                for (int k = 0; k < scd_pkg::WAYS; k++) begin
                    tv_q[k][s] <= scd_pkg::TV_RST;
                end
            end
        end else if (fill_do) begin
            tv_q[fill_way][look_set[2]] <= 1'b1;
        end
    end

    // invalidation is written last so it beats a same-cycle fill of that line, but only if the line was already valid before that cycle
    always_ff @(posedge core_clk) begin
        if (fill_do) begin
            tag_q[fill_way][look_set[2]] <= fill_addr[scd_pkg::TAG_LSB +: scd_pkg::TAG_W];
            lv_q[fill_way][look_set[2]] <= (way_tag_hit[2][fill_way] ? lv_q[fill_way][look_set[2]] : '0) |
                                           (scd_pkg::LINES'(1) << look_line[2]);
        end
        for (int k = 0; k < scd_pkg::WAYS; k++) begin
            // the whole 16-byte line goes, whatever bytes were written
            if (snp_hit && way_line_hit[1][k]) begin
                lv_q[k][look_set[1]][look_line[1]] <= 1'b0;
            end
            if (nc_inv && way_line_hit[0][k]) begin
                lv_q[k][look_set[0]][look_line[0]] <= 1'b0;
            end
        end
    end

    // replacement way flips per cacheable access, way 0 after reset or disable
    always_ff @(posedge core_clk) begin
        if (!resetn || !cache_enable) begin
            repl_q <= scd_pkg::REPL_RST;
        end else if (acc && cacheable) begin
            repl_q <= !repl_q;
        end
    end

    // ************************************************************
    // write-through and local bus answers
    // ************************************************************
    // every write, hit or miss, is passed on; the cache never holds the sole copy
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wt_valid <= 1'b0;
            wt_req <= '0;
        end else if (acc && lb_req.write) begin
            wt_valid <= 1'b1;
            wt_req <= '{addr: lb_req.addr, byte_enables: lb_req.byte_enables};
        end else if (wt_ready) begin
            wt_valid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            lb_hit <= 1'b0;
            lb_miss <= 1'b0;
        end else begin
            lb_hit <= acc && l_hit;
            lb_miss <= acc && !lb_req.write && !l_hit;
        end
    end

    // ************************************************************
    // sram sequencer
    // ************************************************************
    // pins only ever pull low; enables decide, sram_i is the shared wire level
    assign sram_o = '0;

    scd_sram_seq u_seq (
        .core_clk(core_clk),
        .resetn(resetn),
        .start(seq_start),
        .is_write(lb_req.write),
        .nwords_m1(lb_req.nwords_m1),
        .first_word(lb_req.addr[scd_pkg::WORD_LSB +: scd_pkg::WORD_W]),
        .hit_way(way_line_hit[0][1]),
        .fast_timing(fast_timing),
        .private_hit_low(private_hit_low),
        .busy(seq_busy),
        .done(seq_done),
        .cache_ready(cache_ready),
        .pin_oe(sram_oe)
    );

    // ************************************************************
    // checks
    // ************************************************************
    logic snp_hit_q;
    logic [scd_pkg::WAYS-1:0] snp_ways_q;
    logic [scd_pkg::SET_W-1:0] snp_set_q;
    logic [scd_pkg::LINE_W-1:0] snp_line_q;
    logic nc_inv_q;
    logic [scd_pkg::WAYS-1:0] nc_ways_q;
    logic [scd_pkg::SET_W-1:0] nc_set_q;
    logic [scd_pkg::LINE_W-1:0] nc_line_q;

    always_ff @(posedge core_clk) begin
        snp_hit_q <= resetn && snp_hit;
        snp_ways_q <= way_line_hit[1];
        snp_set_q <= look_set[1];
        snp_line_q <= look_line[1];
        nc_inv_q <= resetn && nc_inv;
        nc_ways_q <= way_line_hit[0];
        nc_set_q <= look_set[0];
        nc_line_q <= look_line[0];
    end

    a_snoop_line_cleared: assert property (@(posedge core_clk) disable iff (!resetn)
        snp_hit_q |-> !(snp_ways_q[0] && lv_q[0][snp_set_q][snp_line_q]) &&
            !(snp_ways_q[1] && lv_q[1][snp_set_q][snp_line_q]))
        else $error("snoop hit left line valid");
    a_reset_dir_empty: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(resetn) |-> !tv_q[0][0] && !tv_q[1][0] && lb_hit == 1'b0)
        else $error("directory not empty after reset");
    a_repl_toggles: assert property (@(posedge core_clk) disable iff (!resetn)
        acc && cacheable |=> !cache_enable || repl_q != $past(repl_q))
        else $error("replacement way did not toggle");
    a_repl_way_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        !cache_enable |=> repl_q == 1'b0)
        else $error("replacement not back at way 0");
    a_write_through: assert property (@(posedge core_clk) disable iff (!resetn)
        acc && lb_req.write |=> wt_valid && wt_req.addr == $past(lb_req.addr))
        else $error("write not passed to system bus");
    a_write_miss_noalloc: assert property (@(posedge core_clk) disable iff (!resetn)
        acc && lb_req.write && !l_hit |=> !seq_busy ##1 !seq_busy)
        else $error("write miss started cache access");
    a_tag_valid_gate: assert property (@(posedge core_clk) disable iff (!resetn)
        way_line_hit[0][0] |-> tv_q[0][look_set[0]])
        else $error("hit on entry with tag-valid clear");
    a_access_ends: assert property (@(posedge core_clk) disable iff (!resetn)
        seq_start |-> ##[4:12] seq_done)
        else $error("cache access did not finish");

    a_nc_line_cleared: assert property (@(posedge core_clk) disable iff (!resetn)
        nc_inv_q |-> !(nc_ways_q[0] && lv_q[0][nc_set_q][nc_line_q]) &&
            !(nc_ways_q[1] && lv_q[1][nc_set_q][nc_line_q]))
        else $error("non-cacheable write left line valid");

    sequence s_hit_answer;
        lb_hit && !lb_miss && seq_busy;
    endsequence

    a_hit_answer: assert property (@(posedge core_clk) disable iff (!resetn)
        acc && l_hit |=> s_hit_answer)
        else $error("hit not answered");
    a_hit_way_pin: assert property (@(posedge core_clk) disable iff (!resetn)
        acc && l_hit |=> sram_oe.way_select_hit == $past(way_line_hit[0][1]))
        else $error("way pin does not name hit way");
    a_read_miss_answer: assert property (@(posedge core_clk) disable iff (!resetn)
        acc && !lb_req.write && !l_hit |=> lb_miss && !lb_hit && !seq_busy)
        else $error("read miss not answered");
    a_recovery_ready: assert property (@(posedge core_clk) disable iff (!resetn)
        seq_done |-> cache_ready)
        else $error("ready missing in recovery cycle");

endmodule

/* File: tb/scd_far_end.sv */
// far-end model: system bus acceptor and pulled-up sram pins
`timescale 1ns/1ps
module scd_far_end (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // write-through
    input wire logic wt_valid,
    output logic wt_ready,
    // local bus side of the sram support logic
    input wire logic cache_ready,
    input wire logic is_write,
    input wire logic [3:0] byte_enables,
    output logic [3:0] chip_sel,
    // sram pins
    input wire scd_pkg::scd_od_t sram_oe,
    output scd_pkg::scd_od_t sram_i
);
    logic [1:0] wait_q;
    logic [3:0] be_q;
    always_ff @(posedge core_clk) begin
        be_q <= (!resetn || !is_write) ? 4'h0 : (cache_ready ? byte_enables : be_q);
    end
    assign chip_sel = !sram_i.cache_read_strobe ? 4'hf : (!sram_i.cache_write_strobe ? be_q : 4'h0);
    // pull-ups: a released pin reads high
    assign sram_i = ~sram_oe;
    // stalls each write-through so the port stays closed
    always_ff @(posedge core_clk) begin
        wait_q <= (!resetn || !wt_valid || wt_ready) ? 2'h0 : wait_q + 2'h1;
        wt_ready <= resetn && wt_valid && !wt_ready && wait_q == 2'h2;
    end
endmodule

/* File: tb/scd_cache_dir_tb.sv */
// self-checking bench for the cache directory
`timescale 1ns/1ps
module scd_cache_dir_tb;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cache_enable = 1'b1;
    logic fast_timing = 1'b1;
    logic private_hit_low = 1'b0;
    logic lb_valid = 1'b0;
    scd_pkg::scd_lreq_t lb_req = '0;
    logic snoop_valid = 1'b0;
    logic fill_valid = 1'b0;
    logic [31:0] snoop_addr = 32'h0;
    logic [31:0] fill_addr = 32'h0;
    logic lb_ready, lb_hit, lb_miss, cache_ready, wt_valid, wt_ready, repl_way;
    scd_pkg::scd_wt_t wt_req;
    scd_pkg::scd_od_t sram_o, sram_oe, sram_i;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc;
    int t[4];
    logic [3:0] seen;
    logic [3:0] chip_sel, cs, wds;
    logic [1:0] ways;
    int rdy;
    localparam logic [31:0] A = 32'h0001_2340;
    localparam logic [31:0] B = 32'h0001_2350;
    localparam logic [31:0] C = 32'h0004_5600;
    always #25 core_clk = ~core_clk;
    scd_cache_dir dut (.core_clk(core_clk), .resetn(resetn), .cache_enable(cache_enable),
        .fast_timing(fast_timing), .private_hit_low(private_hit_low), .tag_mask(20'hfffff), .line_mask(8'hff),
        .interleave_log2(2'h0), .unit_id(2'h0), .lb_valid(lb_valid), .lb_req(lb_req),
        .lb_ready(lb_ready), .lb_hit(lb_hit), .lb_miss(lb_miss), .cache_ready(cache_ready),
        .wt_valid(wt_valid), .wt_req(wt_req), .wt_ready(wt_ready), .snoop_valid(snoop_valid),
        .snoop_addr(snoop_addr), .fill_valid(fill_valid), .fill_addr(fill_addr),
        .repl_way(repl_way), .sram_o(sram_o), .sram_oe(sram_oe), .sram_i(sram_i));
    scd_far_end far (.core_clk(core_clk), .resetn(resetn), .wt_valid(wt_valid),
        .wt_ready(wt_ready), .cache_ready(cache_ready), .is_write(lb_req.write),
        .byte_enables(lb_req.byte_enables), .chip_sel(chip_sel), .sram_oe(sram_oe), .sram_i(sram_i));
    // ****************
    // tasks
    // ****************
    task automatic results();
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic snp, input logic [31:0] a);
        @(posedge core_clk);
        if (snp) begin snoop_valid <= 1'b1; snoop_addr <= a; end
        else begin fill_valid <= 1'b1; fill_addr <= a; end
        @(posedge core_clk);
        snoop_valid <= 1'b0;
        fill_valid <= 1'b0;
    endtask
    // collects write-through, hit, miss, strobe and the cycles until the port reopens
    task automatic acc(input logic [31:0] a, input logic wr, input logic cb, input logic [1:0] nw);
        @(posedge core_clk);
        lb_valid <= 1'b1;
        lb_req <= '{a, wr ? 4'h6 : 4'hf, wr, cb, nw};
        @(posedge core_clk);
        lb_valid <= 1'b0;
        seen = 4'h0;
        rdy = 0;
        cs = 4'h0;
        ways = 2'h0;
        wds = 4'h0;
        for (cyc = 0; cyc < 40; cyc++) begin
            #1;
            seen |= {wt_valid, lb_hit, lb_miss, wr ? sram_oe.cache_write_strobe : sram_oe.cache_read_strobe};
            rdy += int'(cache_ready);
            cs |= chip_sel;
            ways |= {sram_oe.way_select_private, sram_oe.way_select_hit};
            if (sram_oe.cache_read_strobe) wds |= 4'h1 << sram_oe.word_address_bits;
            if (cyc > 1 && lb_ready === 1'b1) break;
            @(posedge core_clk);
        end
        if (cyc == 40) begin bad_count++; $display("unexpected at %0t: port stuck", $time); results(); end
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        #1;
        chk({lb_ready, repl_way, sram_oe, sram_o}, 14'h2000);
        acc(A, 1'b0, 1'b1, 2'h0);
        chk(seen, 4'h2);
        pulse(1'b0, A);
        pulse(1'b0, B);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            fast_timing <= !i[0];
            private_hit_low <= i[0];
            acc(A, 1'b0, 1'b1, i[1] ? 2'h3 : 2'h0);
            chk(seen, 4'h5);
            chk({8'(rdy), wds}, i[1] ? 12'h06f : 12'h031);
            chk({ways, cs}, {i[0], 1'b1, 4'hf});
            t[i] = cyc;
        end
        chk({8'(t[1] - t[0]), 8'(t[2] - t[0]), 8'(t[3] - t[0])}, 24'h010307);
        acc(A, 1'b1, 1'b1, 2'h0);
        chk(seen, 4'hd);
        chk({wt_req, cs}, {A, 4'h6, 4'h6});
        pulse(1'b1, A | 32'h5);
        acc(A, 1'b0, 1'b1, 2'h0);
        chk(seen, 4'h2);
        acc(B, 1'b0, 1'b1, 2'h0);
        chk(seen, 4'h5);
        acc(B, 1'b1, 1'b0, 2'h0);
        chk(seen, 4'h8);
        acc(B, 1'b0, 1'b1, 2'h0);
        chk(seen, 4'h2);
        acc(C, 1'b1, 1'b1, 2'h0);
        chk(seen, 4'h8);
        acc(C, 1'b0, 1'b1, 2'h0);
        chk({seen, repl_way}, 5'h05);
        @(posedge core_clk);
        cache_enable <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(repl_way, 1'b0);
        results();
    end
endmodule
